// file: design/twr_consts.vh
/*
  constants for the watchdog relay terminal: octet fields, register indices,
  reset values and timing. assumes inclusion by bare name from design files.
*/
`ifndef TWR_CONSTS_VH
`define TWR_CONSTS_VH

// ----------------------------------------------------------------
// control and status octet fields
// ----------------------------------------------------------------
`define TWR_BIT_REGSEL      7
`define TWR_BIT_WRITE       6
`define TWR_BIT_HEARTBEAT   0
`define TWR_BIT_ARMED       1
`define TWR_BIT_IN1         2
`define TWR_BIT_IN2         3
`define TWR_IDX_HI          5

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define TWR_R_DIAG          6'h06
`define TWR_R_CMD           6'h07
`define TWR_R_TYPE          6'h08
`define TWR_R_FW            6'h09
`define TWR_R_MUX           6'h0a
`define TWR_R_SIGCH         6'h0b
`define TWR_R_MINLEN        6'h0c
`define TWR_R_DSTRUCT       6'h0d
`define TWR_R_ALIGN         6'h0f
`define TWR_R_HWVER         6'h10
`define TWR_R_KEY           6'h1f
`define TWR_R_FEATURE       6'h20
`define TWR_R_SUPER         6'h23
`define TWR_R_MINOFF        6'h24

// ----------------------------------------------------------------
// reset values and fixed contents
// ----------------------------------------------------------------
`define TWR_ZERO16          16'h0000
`define TWR_MUX_VAL         16'h0118
`define TWR_SIGCH_VAL       16'h0118
`define TWR_MINLEN_VAL      16'h1818
`define TWR_SUPER_RST       16'h0008
`define TWR_MINOFF_RST      16'h0064
`define TWR_UNLOCK_KEY      16'h1235

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TWR_CLK_HZ          40000000
`define TWR_TICK_US         500
`define TWR_TICK_CYC        ((`TWR_CLK_HZ / 1000000) * `TWR_TICK_US)

`endif

// file: design/twr_sync2.v
/*
  two flip-flop synchroniser for pin levels, WIDTH bits wide.
  assumes inputs are asynchronous levels; the first stage feeds only the second.
*/
`timescale 1ns/100ps
`default_nettype none

module twr_sync2 #(
  parameter WIDTH = 2
) (
  input  wire             ref_clk,
  input  wire             rst_b,
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] meta_reg;

  // ----------------------------------------------------------------
  // two stage capture
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_reg <= {WIDTH{1'b0}};
      dout     <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end

endmodule
`default_nettype wire

// file: design/twr_terminal.v
/*
  watchdog relay terminal core: process image exchange, register map,
  heartbeat supervision and relay hold-off.
  assumes the coupler presents control_octet/data_out with a one-cycle
  image_strobe on ref_clk; status inputs are asynchronous pins. nonvolatile
  storage is modelled as a shadow plus a commit strobe to the outside.
*/
// Behaviour
// RULE1: process data mode drives status bit 7 low.
// RULE2: status bit 1 shows watchdog armed with relays energised.
// RULE3: process data mode echoes the heartbeat bit into status bit 0.
// RULE4: status bits 3..2 carry the two status inputs, bits 6..4 zero.
// RULE5: controller sets control bit 7 to start register access.
// RULE6: controller keeps bit 7 and reserved bits low in process mode.
// RULE7: control bit 6 high means write, low means read.
// RULE8: bits 5..0 index the register; read returns it, write takes data.
// RULE9: register mode drives status bit 7 high.
// RULE10: register reply echoes the accessed index in status bits 5..0.
// RULE11: write reply equals control octet with bit 6 clear; data invalid.
// RULE12: heartbeat must toggle each supervision period or relays drop.
// RULE13: diagnostic and command registers exist, reset zero, diagnostic read-only.
// RULE14: register 8 holds a fixed read-only terminal type code.
// RULE15: register 9 holds read-only firmware version as two ASCII bytes.
// RULE16: register 16 holds hardware version, kept nonvolatile.
// RULE17: user register writes rejected unless unlock key is in register 31.
// RULE18: unlocked user writes go to working and nonvolatile copies.
// RULE19: unlock key register clears on every restart.
// RULE20: register 32 is read/write nonvolatile feature config, default zero.
// RULE21: supervision period is register 35 times 500 us, default 4 ms.
// RULE22: after a trip relays stay off for register 36 times 500 us.
// RULE23: reserved indices read zero and ignore writes.
`timescale 1ns/100ps
`default_nettype none
`include "twr_consts.vh"

module twr_terminal #(
  parameter TICK_CYC  = `TWR_TICK_CYC,
  parameter TYPE_CODE = 16'h5a5a,   // arbitrary identity value
  parameter FW_ASCII  = 16'h3030,   // arbitrary firmware text
  parameter HW_VER    = 16'h0000
) (
  input  wire        ref_clk,
  input  wire        rst_b,
  input  wire        image_strobe,
  input  wire [7:0]  control_octet,
  input  wire [15:0] data_out,
  input  wire [1:0]  status_pins,
  output reg  [7:0]  status_octet,
  output reg  [15:0] data_in,
  output reg         relay_on,
  output reg         nv_commit,
  output reg  [5:0]  nv_index,
  output reg  [15:0] nv_data
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  wire        tick;
  wire [1:0]  pins_sync;
  reg  [15:0] cmd_reg;
  reg  [15:0] align_reg;
  reg  [15:0] hwver_reg;
  reg  [15:0] key_reg;
  reg  [15:0] feature_reg;
  reg  [15:0] super_reg;
  reg  [15:0] minoff_reg;
  reg  [15:0] rd_next;
  reg         hb_reg;
  reg  [15:0] wd_cnt_reg;
  reg  [15:0] off_cnt_reg;
  reg  [1:0]  state_reg;
  wire        reg_mode  = control_octet[`TWR_BIT_REGSEL];     // RULE5
  wire        wr_access = control_octet[`TWR_BIT_WRITE];      // RULE7
  wire [5:0]  index     = control_octet[`TWR_IDX_HI:0];       // RULE8
  wire        unlocked  = (key_reg == `TWR_UNLOCK_KEY);
  wire        hb_edge   = image_strobe && !reg_mode &&
                          (control_octet[`TWR_BIT_HEARTBEAT] != hb_reg);

  localparam ST_IDLE  = 2'b00;
  localparam ST_ARMED = 2'b01;
  localparam ST_HOLD  = 2'b10;

  twr_tick_gen #(.TICK_CYC(TICK_CYC)) u_tick (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .tick    (tick)
  );

  twr_sync2 #(.WIDTH(2)) u_sync (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .din     (status_pins),
    .dout    (pins_sync)
  );

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  always @*
  begin
    case (index)
      `TWR_R_DIAG:    rd_next = `TWR_ZERO16;        // RULE13
      `TWR_R_CMD:     rd_next = cmd_reg;            // RULE13
      `TWR_R_TYPE:    rd_next = TYPE_CODE;          // RULE14
      `TWR_R_FW:      rd_next = FW_ASCII;           // RULE15
      `TWR_R_MUX:     rd_next = `TWR_MUX_VAL;
      `TWR_R_SIGCH:   rd_next = `TWR_SIGCH_VAL;
      `TWR_R_MINLEN:  rd_next = `TWR_MINLEN_VAL;
      `TWR_R_DSTRUCT: rd_next = `TWR_ZERO16;
      `TWR_R_ALIGN:   rd_next = align_reg;
      `TWR_R_HWVER:   rd_next = hwver_reg;          // RULE16
      `TWR_R_KEY:     rd_next = key_reg;
      `TWR_R_FEATURE: rd_next = feature_reg;        // RULE20
      `TWR_R_SUPER:   rd_next = super_reg;
      `TWR_R_MINOFF:  rd_next = minoff_reg;
      default:        rd_next = `TWR_ZERO16;        // RULE23
    endcase
  end

  // ----------------------------------------------------------------
  // register writes; user registers need the unlock key
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cmd_reg     <= `TWR_ZERO16;                   // RULE13
      align_reg   <= `TWR_ZERO16;
      hwver_reg   <= HW_VER;
      key_reg     <= `TWR_ZERO16;                   // RULE19
      feature_reg <= `TWR_ZERO16;                   // RULE20
      super_reg   <= `TWR_SUPER_RST;                // RULE21
      minoff_reg  <= `TWR_MINOFF_RST;               // RULE22
      nv_commit   <= 1'b0;
      nv_index    <= 6'h00;
      nv_data     <= `TWR_ZERO16;
    end
    else
    begin
      nv_commit <= 1'b0;
      if (image_strobe && reg_mode && wr_access)
      begin
        case (index)
          `TWR_R_CMD:   cmd_reg   <= data_out;
          `TWR_R_ALIGN: align_reg <= data_out;
          `TWR_R_KEY:   key_reg   <= data_out;      // any other value re-locks
          default:      ;                           // RULE23
        endcase
        // nonvolatile user registers: only while unlocked
        if (unlocked &&                                                   // RULE17
            (index == `TWR_R_HWVER || index == `TWR_R_FEATURE ||
             index == `TWR_R_SUPER || index == `TWR_R_MINOFF))
        begin
          nv_commit <= 1'b1;                        // RULE18
          nv_index  <= index;
          nv_data   <= data_out;
          case (index)
            `TWR_R_HWVER:   hwver_reg   <= data_out; // RULE16
            `TWR_R_FEATURE: feature_reg <= data_out; // RULE20
            `TWR_R_SUPER:   super_reg   <= data_out;
            default:        minoff_reg  <= data_out;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // status octet and input word, updated per image exchange
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      status_octet <= 8'h00;
      data_in      <= 16'h0000;
    end
    else if (image_strobe)
    begin
      if (reg_mode)
      begin
        // reply mirrors the control octet; write clears bit 6
        status_octet <= {1'b1, 1'b0, index};        // RULE9 RULE10 RULE11
        if (!wr_access)
          data_in <= rd_next;                       // RULE8
        // write reply: data_in left stale, documented as invalid
      end
      else
      begin
        status_octet <= {1'b0, 3'b000, pins_sync[1], pins_sync[0],   // RULE1 RULE4
                         relay_on, control_octet[`TWR_BIT_HEARTBEAT]}; // RULE2 RULE3
        data_in      <= 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // heartbeat supervision and minimum off time
  // counting in 500 us ticks, so trip resolution is one tick
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hb_reg      <= 1'b0;
      wd_cnt_reg  <= 16'h0000;
      off_cnt_reg <= 16'h0000;
      state_reg   <= ST_IDLE;
      relay_on    <= 1'b0;
    end
    else
    begin
      if (image_strobe && !reg_mode)
        hb_reg <= control_octet[`TWR_BIT_HEARTBEAT];
      case (state_reg)
        ST_IDLE:
        begin
          relay_on   <= 1'b0;
          wd_cnt_reg <= 16'h0000;
          if (hb_edge)
          begin
            state_reg <= ST_ARMED;
            relay_on  <= 1'b1;                      // RULE2
          end
        end
        ST_ARMED:
        begin
          if (hb_edge)
            wd_cnt_reg <= 16'h0000;                 // RULE12
          else if (tick)
          begin
            if (wd_cnt_reg + 16'h0001 >= super_reg) // RULE21
            begin
              state_reg   <= ST_HOLD;
              relay_on    <= 1'b0;                  // RULE12
              off_cnt_reg <= 16'h0000;
            end
            else
              wd_cnt_reg <= wd_cnt_reg + 16'h0001;
          end
        end
        ST_HOLD:
        begin
          relay_on <= 1'b0;
          // heartbeat edges ignored until the off time has run
          if (tick)
          begin
            if (off_cnt_reg + 16'h0001 >= minoff_reg) // RULE22
              state_reg <= ST_IDLE;
            else
              off_cnt_reg <= off_cnt_reg + 16'h0001;
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
          relay_on  <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// file: design/twr_tick_gen.v
/*
  divider producing a one-cycle enable every scaling tick (500 us).
  assumes the single ref_clk domain; tick count is a parameter so that
  simulation can shorten it.
*/
`timescale 1ns/100ps
`default_nettype none
`include "twr_consts.vh"

module twr_tick_gen #(
  parameter TICK_CYC = `TWR_TICK_CYC
) (
  input  wire ref_clk,
  input  wire rst_b,
  output reg  tick
);

  reg [31:0] count_reg;

  // ----------------------------------------------------------------
  // free running divider
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count_reg <= 32'h0000_0000;
      tick      <= 1'b0;
    end
    else if (count_reg >= TICK_CYC - 1)
    begin
      count_reg <= 32'h0000_0000;
      tick      <= 1'b1;
    end
    else
    begin
      count_reg <= count_reg + 32'h0000_0001;
      tick      <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: testbench/tb.sv
/*
  self-checking bench for twr_terminal: register map, protection, heartbeat.
  assumes twr_coupler as the far side and a shortened tick of four cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam logic [15:0] TYPE_V = 16'h2c2c; // arbitrary identity value
  localparam logic [15:0] FW_V   = 16'h3242;
  logic        ref_clk, rst_b, hb;
  logic [1:0]  status_pins;
  logic [7:0]  s;
  logic [15:0] r;
  wire         image_strobe, relay_on, nv_commit;
  wire  [7:0]  control_octet, status_octet;
  wire  [15:0] data_out, data_in, nv_data;
  wire  [5:0]  nv_index;
  int          err_count, compares, cyc, nvc;
  logic [21:0] rv [15] = '{{6'h06, 16'h0000}, {6'h07, 16'h0000}, {6'h08, TYPE_V}, {6'h09, FW_V},
    {6'h0a, 16'h0118}, {6'h0b, 16'h0118}, {6'h0c, 16'h1818}, {6'h0d, 16'h0000}, {6'h10, 16'h0001},
    {6'h1f, 16'h0000}, {6'h20, 16'h0000}, {6'h23, 16'h0008}, {6'h24, 16'h0064}, {6'h00, 16'h0000},
    {6'h3f, 16'h0000}};
  logic [5:0]  ro [6] = '{6'h06, 6'h08, 6'h09, 6'h0a, 6'h0e, 6'h3f};

  twr_terminal #(.TICK_CYC(4), .TYPE_CODE(TYPE_V), .FW_ASCII(FW_V), .HW_VER(16'h0001)) i_twr_terminal (
    .ref_clk(ref_clk), .rst_b(rst_b), .image_strobe(image_strobe), .control_octet(control_octet),
    .data_out(data_out), .status_pins(status_pins), .status_octet(status_octet), .data_in(data_in),
    .relay_on(relay_on), .nv_commit(nv_commit), .nv_index(nv_index), .nv_data(nv_data));
  twr_coupler i_twr_coupler (.ref_clk(ref_clk), .image_strobe(image_strobe), .control_octet(control_octet),
    .data_out(data_out), .status_octet(status_octet), .data_in(data_in));

  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ----------------------------------------------------------------
  // bookkeeping and helpers
  // ----------------------------------------------------------------
  // cycle ceiling well above the roughly 780 cycles the run needs
  always @(posedge ref_clk)
  begin
    cyc++;
    if (nv_commit === 1'b1) nvc++;
    if (cyc == 4000)
    begin
      err_count++;
      finish_test();
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [5:0] i, input logic [15:0] e);
    i_twr_coupler.xfer({2'h2, i}, 16'h0000, s, r);
    chk({8'h00, s}, {8'h00, 2'h2, i});
    chk(r, e);
  endtask
  task automatic wr(input logic [5:0] i, input logic [15:0] d);
    i_twr_coupler.xfer({2'h3, i}, d, s, r);
    chk({8'h00, s}, {8'h00, 2'h2, i});
  endtask
  task automatic rst_pulse();
    @(posedge ref_clk);
    #1 rst_b = 1'b0;
    repeat (16) @(posedge ref_clk);
    #1 rst_b = 1'b1;
  endtask
  task automatic finish_test();
    if (err_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_b = 1'b0;
    status_pins = 2'h0;
    hb = 1'b0;
    repeat (16) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    foreach (rv[k]) rd(rv[k][21:16], rv[k][15:0]);
    // locked: read-only, reserved and user places all refuse writes
    foreach (ro[k]) wr(ro[k], 16'hffff);
    wr(6'h20, 16'h0002);
    foreach (rv[k]) rd(rv[k][21:16], rv[k][15:0]);
    chk(nvc[15:0], 16'h0000);
    wr(6'h1f, 16'h1235);
    rd(6'h1f, 16'h1235);
    wr(6'h20, 16'h0002);
    chk({10'h000, nv_index}, 16'h0020);
    chk(nv_data, 16'h0002);
    rd(6'h20, 16'h0002);
    chk(nvc[15:0], 16'h0001);
    wr(6'h1f, 16'h0000);
    wr(6'h20, 16'h0005);
    rd(6'h20, 16'h0002);
    rst_pulse();
    rd(6'h1f, 16'h0000);
    // heartbeat every eight cycles keeps the relay up
    status_pins = 2'h2;
    i_twr_coupler.beat(6, 6, hb, s);
    chk({8'h00, s}, {12'h000, status_pins, 1'b1, hb});
    // look just after the edge so the relay level has settled
    repeat (20) @(posedge ref_clk);
    #1;
    chk({15'h0000, relay_on}, 16'h0001);
    repeat (30) @(posedge ref_clk);
    #1;
    chk({15'h0000, relay_on}, 16'h0000);
    // resumed heartbeat must not re-arm before the off time has run
    status_pins = 2'h1;
    i_twr_coupler.beat(30, 6, hb, s);
    chk({8'h00, s}, {12'h000, status_pins, 1'b0, hb});
    i_twr_coupler.beat(40, 6, hb, s);
    chk({15'h0000, relay_on}, 16'h0001);
    finish_test();
  end
endmodule
`default_nettype wire

// file: testbench/twr_coupler.sv
/*
  coupler model: drives the cyclic process image into the terminal.
  assumes ref_clk from the bench; a reply stands one cycle after the strobe.
*/
`timescale 1ns/100ps
`default_nettype none
module twr_coupler (
  input  wire logic        ref_clk,
  output var  logic        image_strobe,
  output var  logic [7:0]  control_octet,
  output var  logic [15:0] data_out,
  input  wire logic [7:0]  status_octet,
  input  wire logic [15:0] data_in
);
  logic [15:0] junk;
  initial
  begin
    image_strobe = 1'b0;
    control_octet = 8'h00;
    data_out = 16'h0000;
  end
  // one exchange; idle lines are inverted so a stale value never looks valid
  task automatic xfer(input logic [7:0] c, input logic [15:0] d, output logic [7:0] s, output logic [15:0] r);
    @(posedge ref_clk);
    #1;
    image_strobe = 1'b1;
    control_octet = c;
    data_out = d;
    @(posedge ref_clk);
    #1;
    image_strobe = 1'b0;
    control_octet = ~c;
    data_out = ~d;
    s = status_octet;
    r = data_in;
  endtask
  // process mode heartbeat: reserved bits low, level flipped each exchange
  task automatic beat(input int n, input int gap, inout logic lvl, output logic [7:0] s);
    repeat (n)
    begin
      repeat (gap) @(posedge ref_clk);
      lvl = ~lvl;
      xfer({7'h00, lvl}, 16'h0000, s, junk);
    end
  endtask
endmodule
`default_nettype wire

// file: testbench/twr_terminal_properties.sv
/*
  port checker for the watchdog relay terminal.
  assumes a bind onto twr_terminal and a single ref_clk domain.
*/
`timescale 1ns/100ps
`default_nettype none
module twr_terminal_chk (
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        image_strobe,
  input wire logic [7:0]  control_octet,
  input wire logic [15:0] data_out,
  input wire logic [7:0]  status_octet,
  input wire logic [15:0] data_in,
  input wire logic        relay_on,
  input wire logic        nv_commit,
  input wire logic [5:0]  nv_index,
  input wire logic [15:0] nv_data
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------------------------------
  // reply octet, one cycle after the taking edge
  // ----------------------------------------------------------------
  a_proc_ack_low: assert property (
    image_strobe && !control_octet[7] |=> !status_octet[7]) else $error("process reply flags register mode");
  a_reg_ack_high: assert property (
    image_strobe && control_octet[7] |=> status_octet[7]) else $error("register reply lacks ack");
  a_hb_echo: assert property (
    image_strobe && !control_octet[7] |=> status_octet[0] == $past(control_octet[0])) else $error("heartbeat not echoed");
  a_spare_bits_zero: assert property (
    image_strobe && !control_octet[7] |=> status_octet[6:4] == 3'h0) else $error("spare status bits set");
  a_index_echo: assert property (
    image_strobe && control_octet[7] |=> status_octet[5:0] == $past(control_octet[5:0])) else $error("index not echoed");
  a_write_reply: assert property (
    image_strobe && control_octet[7:6] == 2'h3 |=> status_octet == ($past(control_octet) & 8'hbf))
    else $error("write reply wrong");
  // ----------------------------------------------------------------
  // storage and relay
  // ----------------------------------------------------------------
  // a commit must come from the write just taken, never on its own
  a_nv_cause: assert property (
    nv_commit |-> $past(image_strobe && control_octet[7:6] == 2'h3) && nv_index == $past(control_octet[5:0])
    && nv_data == $past(data_out)) else $error("stray nonvolatile commit");
  a_relay_rise: assert property (
    $rose(relay_on) |-> $past(image_strobe && !control_octet[7])) else $error("relay armed without heartbeat");
  // bench keeps the off time far above eight cycles
  a_relay_hold: assert property (
    $fell(relay_on) |=> !relay_on [*8]) else $error("relay re-energised too soon");
  c_write: cover property (nv_commit);
  c_trip: cover property ($fell(relay_on));
  c_read: cover property (image_strobe && control_octet[7:6] == 2'h2);
endmodule
bind twr_terminal twr_terminal_chk i_chk (.ref_clk(ref_clk), .rst_b(rst_b), .image_strobe(image_strobe),
  .control_octet(control_octet), .data_out(data_out), .status_octet(status_octet), .data_in(data_in),
  .relay_on(relay_on), .nv_commit(nv_commit), .nv_index(nv_index), .nv_data(nv_data));
`default_nettype wire
